// ---- common/pac_pkg.sv ----
/*
 * shared constants, types and helpers of the pipelined sampling
 * converter output control block.
 * assumes: a 100 MHz system clock and a slow encode strobe (125 ns).
 */
// Contract
// - conversion starts on encode rising edge
// - encode high when positive leg exceeds negative
// - track while encode low, freeze on rise
// - result appears five encode cycles after sampling
// - adjacent stages load on opposite encode edges
// - stage results aligned and merged before output
// - normal run; outputs driven when enable low
// - power-down gives nap or sleep, outputs off
// - style select picks full, demux or differential
// - format select picks coding and stabilizer
// - differential: twelve pairs, top pair is msb
// - range flag high, aligned with its word
// - simultaneous demux: latency five and six
package pac_pkg;

  // ==========================================================
  // widths and pipeline figures
  localparam int WORD_W = 12;
  localparam int MSB_IDX = WORD_W - 1;
  localparam int NUM_STAGES = 5;
  localparam int LATENCY_CYC = 5;

  // stage slices: each stage resolves its own group of bits
  localparam logic [11:0] SLICE_MASK [NUM_STAGES] = '{
    12'he00, 12'h1c0, 12'h030, 12'h00c, 12'h003};

  // ==========================================================
  // output style and format encodings
  localparam logic [1:0] STYLE_FULL = 2'h0;
  localparam logic [1:0] STYLE_SIMUL = 2'h1;
  localparam logic [1:0] STYLE_INTLV = 2'h2;
  localparam logic [1:0] STYLE_DIFF = 2'h3;
  localparam logic [1:0] FMT_OB_OFF = 2'h0;
  localparam logic [1:0] FMT_OB_ON = 2'h1;
  localparam logic [1:0] FMT_TC_ON = 2'h2;
  localparam logic [1:0] FMT_TC_OFF = 2'h3;

  // ==========================================================
  // register map
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam int EV_WORD = 0;
  localparam int EV_RANGE = 1;
  localparam int EV_W = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {OP_NORMAL, OP_NAP, OP_SLEEP} pac_op_t;

  typedef struct packed {
    logic oe_n;
    logic power_down_select;
    logic [1:0] fmt;
    logic [1:0] style;
  } pac_ctrl_t;

  localparam pac_ctrl_t CTRL_RESET = 6'h03;

  typedef struct packed {
    logic over;
    logic [11:0] code;
  } pac_sample_t;

  typedef struct packed {
    logic data_valid_strobe;
    logic range_exceed_flag;
    logic [11:0] sample_bits;
  } pac_bus_t;

  // two's complement is offset binary with the msb turned over
  function automatic logic [11:0] pac_format(input logic [11:0] code,
                                             input logic twos);
    return {code[MSB_IDX] ^ twos, code[MSB_IDX-1:0]};
  endfunction

  function automatic logic pac_is_twos(input logic [1:0] fmt);
    return (fmt == FMT_TC_ON) || (fmt == FMT_TC_OFF);
  endfunction

endpackage

// ---- rtl/pac_pipe.sv ----
/*
 * five-stage conversion pipeline with alignment and correction.
 * assumes: encode edges arrive as one-cycle pulses on clk_i.
 */
`timescale 1ns/1ns
module pac_pipe #(
  parameter int STAGES = pac_pkg::NUM_STAGES,
  parameter int LAT = pac_pkg::LATENCY_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // encode edges and run control
  input wire logic enc_rise_i,
  input wire logic enc_fall_i,
  input wire logic run_i,
  // held sample in, corrected word out
  input wire pac_pkg::pac_sample_t sample_i,
  output pac_pkg::pac_sample_t word_o,
  output logic word_valid_o
);
  import pac_pkg::*;

  localparam int ALIGN = LAT - (STAGES + 1) / 2;

  pac_sample_t acc_r [STAGES];
  logic [11:0] res_r [STAGES];
  pac_sample_t in_acc [STAGES];
  logic [11:0] in_res [STAGES];
  pac_sample_t align_r [ALIGN];
  pac_sample_t merged;
  logic [3:0] fill_r;
  wire rise_run = enc_rise_i & run_i;

  // ==========================================================
  // stage inputs: first stage reads the held sample
  assign in_acc[0] = '{over: sample_i.over, code: '0};
  assign in_res[0] = sample_i.code;
  for (genvar k = 1; k < STAGES; k++) begin : g_link
    assign in_acc[k] = acc_r[k-1];
    assign in_res[k] = res_r[k-1];
  end

  // each stage resolves its slice and passes the residue on
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < STAGES; k++) begin
      if (rst_i) begin
        acc_r[k] <= '0;
        res_r[k] <= '0;
      end else if (run_i && ((k % 2 == 0) ? enc_fall_i : enc_rise_i)) begin
        acc_r[k].over <= in_acc[k].over;
        acc_r[k].code <= in_acc[k].code | (in_res[k] & SLICE_MASK[k]);
        res_r[k] <= in_res[k] & ~SLICE_MASK[k];
      end
    end
  end

  // ==========================================================
  // correction merges slices; alignment pads latency
  assign merged = '{over: acc_r[STAGES-1].over,
                    code: acc_r[STAGES-1].code | res_r[STAGES-1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ALIGN; i++) align_r[i] <= '0;
    end else if (rise_run) begin
      align_r[0] <= merged;
      for (int i = 1; i < ALIGN; i++) align_r[i] <= align_r[i-1];
    end
  end

  // output word and a fill count that hides start-up garbage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o <= '0;
      word_valid_o <= 1'b0;
      fill_r <= '0;
    end else begin
      word_valid_o <= rise_run && (fill_r == 4'(LAT));
      if (rise_run) begin
        word_o <= align_r[ALIGN-1];
        if (fill_r != 4'(LAT)) fill_r <= fill_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stage_phase_a: assert property ($changed(res_r[0]) |-> $past(enc_fall_i))
    else $error("first stage loaded off the falling edge");
  stage_two_a: assert property ($changed(acc_r[1]) |-> $past(enc_rise_i))
    else $error("second stage loaded off the rising edge");
  word_fill_a: assert property (word_valid_o |-> fill_r == 4'(LAT))
    else $error("word issued before pipeline filled");
  merge_full_a: assert property ($past(rise_run) |-> align_r[0] == $past(merged))
    else $error("corrected word not captured");

endmodule // pac_pipe

// ---- rtl/pac_top.sv ----
/*
 * output control of a 12-bit pipelined sampling converter: encode
 * sampling, pipeline, output styles, formats, power modes, registers.
 * assumes: classic wishbone master on clk_i; encode and analog code
 * arrive from outside the clock domain and are synchronised here.
 */
`timescale 1ns/1ns
module pac_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pac_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // encode strobe and converted analog value
  input wire logic sample_strobe_p_i,
  input wire logic sample_strobe_n_i,
  input wire logic [11:0] analog_code_i,
  input wire logic analog_over_i,
  // output buses, enables low while driving
  output pac_pkg::pac_bus_t bus_a_p_o,
  output pac_pkg::pac_bus_t bus_a_n_o,
  output pac_pkg::pac_bus_t bus_b_o,
  output logic bus_a_oe_n_o,
  output logic bus_b_oe_n_o,
  // status
  output logic stabilizer_on_o,
  output logic irq_o
);
  import pac_pkg::*;

  // ==========================================================
  // declarations
  logic enc_p_s1_r, enc_p_s2_r, enc_n_s1_r, enc_n_s2_r, enc_r;
  pac_sample_t ana_s1_r, ana_s2_r, track_r, held_r;
  pac_ctrl_t ctrl_r;
  logic [EV_W-1:0] stat_r, mask_r, stat_nxt, ev, clr;
  pac_sample_t last_r, prev_r, pipe_word;
  pac_bus_t a_r, b_r, a_nxt, b_nxt;
  logic phase_r, ack_r, word_valid;
  logic [31:0] dat_r, rd_mux;
  logic [11:0] fw;
  pac_op_t op;

  // ==========================================================
  // two-flop synchronisers for every outside input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_p_s1_r <= 1'b0;
      enc_p_s2_r <= 1'b0;
      enc_n_s1_r <= 1'b0;
      enc_n_s2_r <= 1'b0;
      ana_s1_r <= '0;
      ana_s2_r <= '0;
    end else begin
      enc_p_s1_r <= sample_strobe_p_i;
      enc_p_s2_r <= enc_p_s1_r;
      enc_n_s1_r <= sample_strobe_n_i;
      enc_n_s2_r <= enc_n_s1_r;
      ana_s1_r <= '{over: analog_over_i, code: analog_code_i};
      ana_s2_r <= ana_s1_r;
    end
  end

  // ==========================================================
  // encode level and edges
  wire enc_now = enc_p_s2_r & ~enc_n_s2_r;
  wire enc_rise = enc_now & ~enc_r;
  wire enc_fall = ~enc_now & enc_r;

  // mode decode
  assign op = !ctrl_r.power_down_select ? OP_NORMAL :
              (ctrl_r.oe_n ? OP_SLEEP : OP_NAP);
  wire run = (op != OP_SLEEP);
  wire drive_a = (op == OP_NORMAL) && !ctrl_r.oe_n;
  wire demux = (ctrl_r.style == STYLE_SIMUL) ||
               (ctrl_r.style == STYLE_INTLV);
  wire twos = pac_is_twos(ctrl_r.fmt);
  wire stab = (ctrl_r.fmt == FMT_OB_ON) || (ctrl_r.fmt == FMT_TC_ON);

  // track while encode low, freeze at the rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_r <= 1'b0;
      track_r <= '0;
      held_r <= '0;
    end else begin
      enc_r <= enc_now;
      if (!enc_now) track_r <= ana_s2_r;
      if (enc_rise && run) held_r <= track_r;
    end
  end

  // ==========================================================
  // conversion pipeline
  pac_pipe #(
    .STAGES(NUM_STAGES),
    .LAT(LATENCY_CYC)
  ) u_pipe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enc_rise_i(enc_rise),
    .enc_fall_i(enc_fall),
    .run_i(run),
    .sample_i(held_r),
    .word_o(pipe_word),
    .word_valid_o(word_valid)
  );

  assign fw = pac_format(pipe_word.code, twos);

  // ==========================================================
  // output bus next values per style
  always_comb begin
    a_nxt = a_r;
    b_nxt = b_r;
    if (word_valid) begin
      if (!demux || phase_r) begin
        a_nxt = '{data_valid_strobe: 1'b1,
                  range_exceed_flag: pipe_word.over,
                  sample_bits: fw};
      end
      if (demux && phase_r) begin
        b_nxt.data_valid_strobe = 1'b0;
        if (ctrl_r.style == STYLE_SIMUL) begin
          b_nxt.range_exceed_flag = prev_r.over;
          b_nxt.sample_bits = prev_r.code;
        end
      end
      if (demux && !phase_r) begin
        a_nxt.data_valid_strobe = 1'b0;
        b_nxt.data_valid_strobe = 1'b1;
        if (ctrl_r.style == STYLE_INTLV) begin
          b_nxt.range_exceed_flag = pipe_word.over;
          b_nxt.sample_bits = fw;
        end
      end
    end else if (enc_fall && !demux) begin
      a_nxt.data_valid_strobe = 1'b0;
    end
  end

  // output registers; negative legs mirror the positive ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_r <= '0;
      b_r <= '0;
      bus_a_n_o <= '1;
      phase_r <= 1'b0;
      prev_r <= '0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      bus_a_n_o <= ~a_nxt;
      if (word_valid) phase_r <= ~phase_r;
      if (word_valid && !phase_r) prev_r <= '{over: pipe_word.over,
                                              code: fw};
    end
  end
  assign bus_a_p_o = a_r;
  assign bus_b_o = b_r;

  // enables, stabilizer state and last word for readback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_a_oe_n_o <= 1'b1;
      bus_b_oe_n_o <= 1'b1;
      stabilizer_on_o <= 1'b0;
      last_r <= '0;
    end else begin
      bus_a_oe_n_o <= ~drive_a;
      bus_b_oe_n_o <= ~(drive_a && demux);
      stabilizer_on_o <= stab;
      if (word_valid) last_r <= '{over: pipe_word.over, code: fw};
    end
  end

  // ==========================================================
  // wishbone decode
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr = req && wb_we_i;
  wire wr_ctrl = wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
  wire wr_mask = wr && (wb_adr_i == REG_MASK) && wb_sel_i[0];
  wire wr_stat = wr && (wb_adr_i == REG_STAT) && wb_sel_i[0];

  assign rd_mux = (wb_adr_i == REG_CTRL) ? 32'(ctrl_r) :
                  (wb_adr_i == REG_STAT) ? 32'(stat_r) :
                  (wb_adr_i == REG_MASK) ? 32'(mask_r) :
                  (wb_adr_i == REG_DATA) ? 32'({op, stab, last_r}) :
                  32'h0000_0000;

  // sticky events, written one clears, a new event wins
  assign ev[EV_WORD] = word_valid;
  assign ev[EV_RANGE] = word_valid && pipe_word.over;
  assign clr = wr_stat ? wb_dat_i[EV_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr) | ev;

  // register file and single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= '0;
      stat_r <= '0;
      ack_r <= 1'b0;
      dat_r <= '0;
      irq_o <= 1'b0;
    end else begin
      ack_r <= req;
      if (req) dat_r <= rd_mux;
      if (wr_ctrl) ctrl_r <= wb_dat_i[$bits(pac_ctrl_t)-1:0];
      if (wr_mask) mask_r <= wb_dat_i[EV_W-1:0];
      stat_r <= stat_nxt;
      irq_o <= |(stat_nxt & mask_r);
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_simul_upd;
    word_valid && phase_r && (ctrl_r.style == STYLE_SIMUL);
  endsequence

  sequence s_full_fall;
    enc_fall && !word_valid && !demux;
  endsequence

  enc_level_a: assert property (
    (enc_p_s2_r && !enc_n_s2_r && !enc_r) ##1 enc_r |-> $past(enc_rise))
    else $error("encode high not seen as rising edge");
  enc_rise_a: assert property (
    $rose(enc_r) |-> $past(enc_p_s2_r && !enc_n_s2_r && enc_rise))
    else $error("rise not flagged on encode going high");
  track_hold_a: assert property (
    (enc_rise && run) |=> held_r == $past(track_r))
    else $error("held sample differs from tracked value");
  hold_still_a: assert property (
    !(enc_rise && run) |=> held_r == $past(held_r))
    else $error("held sample moved without a rising edge");
  out_enable_a: assert property (
    (!ctrl_r.power_down_select && !ctrl_r.oe_n) |=> !bus_a_oe_n_o)
    else $error("outputs not driven in normal mode");
  sleep_nap_a: assert property (
    ctrl_r.power_down_select |=> bus_a_oe_n_o && bus_b_oe_n_o)
    else $error("outputs driven while powered down");
  style_sel_a: assert property (
    (ctrl_r.style == STYLE_DIFF) |=> bus_b_oe_n_o)
    else $error("second bus driven in differential style");
  fmt_stab_a: assert property (
    (ctrl_r.fmt == FMT_TC_OFF) |=> !stabilizer_on_o)
    else $error("stabilizer on with it selected off");
  diff_legs_a: assert property (
    (word_valid && !demux) |=> bus_a_n_o.sample_bits == ~bus_a_p_o.sample_bits)
    else $error("negative legs not complement of positive");
  strobe_fall_a: assert property (
    s_full_fall |=> !bus_a_p_o.data_valid_strobe ##1
    !bus_a_p_o.data_valid_strobe || $past(word_valid))
    else $error("strobe not low after encode fall");
  range_flag_a: assert property (
    (word_valid && !demux) |=> bus_a_p_o.range_exceed_flag ==
    $past(pipe_word.over) && bus_a_p_o.data_valid_strobe)
    else $error("range flag not aligned with word");
  twos_msb_a: assert property (
    (word_valid && twos) |=> last_r.code[MSB_IDX] ==
    !$past(pipe_word.code[MSB_IDX]))
    else $error("two's complement msb not inverted");
  simul_late_a: assert property (
    s_simul_upd |=> bus_b_o.sample_bits == $past(prev_r.code, 1))
    else $error("simultaneous second bus not one word late");
  irq_set_a: assert property (
    (ev[EV_RANGE] && mask_r[EV_RANGE]) |=> stat_r[EV_RANGE] && irq_o)
    else $error("event lost or interrupt not raised");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for two cycles");

endmodule // pac_top

// ---- verif/pac_rx_model.sv ----
/* receiver model: latches bus a on the falling positive strobe leg.
   assumes: bus a registered on clk_i, strobe slow against clk_i. */
`timescale 1ns/1ns
module pac_rx_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // differential bus a and its enable
  input wire pac_pkg::pac_bus_t bus_p_i,
  input wire pac_pkg::pac_bus_t bus_n_i,
  input wire logic oe_n_i,
  // captured word
  output pac_pkg::pac_bus_t word_o,
  output logic [15:0] count_o,
  output logic pair_bad_o
);
  import pac_pkg::*;
  logic strobe_r;
  // ==========================================================
  // capture only while the bus is driven; legs must mirror
  always_ff @(posedge clk_i) begin
    strobe_r <= bus_p_i.data_valid_strobe;
    if (rst_i) begin
      count_o <= 16'h0000;
      pair_bad_o <= 1'b0;
    end else begin
      if (strobe_r && !bus_p_i.data_valid_strobe && !oe_n_i) begin
        word_o <= bus_p_i;
        count_o <= count_o + 16'h0001;
      end
      if (bus_n_i !== ~bus_p_i) pair_bad_o <= 1'b1;
    end
  end
endmodule // pac_rx_model

// ---- verif/tb_top.sv ----
/* bench for the converter output control: wishbone register tests,
   encode stream, formats, styles, power modes and interrupt.
   assumes: pac_top and pac_rx_model compiled with pac_pkg. */
`timescale 1ns/1ns
module tb_top;
  import pac_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic sample_strobe_p_i, sample_strobe_n_i, analog_over_i;
  logic [11:0] analog_code_i, nxt;
  pac_bus_t bus_a_p_o, bus_a_n_o, bus_b_o, rx_word;
  logic bus_a_oe_n_o, bus_b_oe_n_o, stabilizer_on_o, irq_o;
  logic [15:0] rx_count, cnt_d, hold;
  logic pair_bad, enc_d, a_d, tc, sim_on, chk_on;
  logic [12:0] hist [0:1023];
  logic [9:0] rises;
  int mismatches, checks, skip, arise;

  pac_top u_pac_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_strobe_p_i(sample_strobe_p_i),
    .sample_strobe_n_i(sample_strobe_n_i), .analog_code_i(analog_code_i),
    .analog_over_i(analog_over_i), .bus_a_p_o(bus_a_p_o),
    .bus_a_n_o(bus_a_n_o), .bus_b_o(bus_b_o), .bus_a_oe_n_o(bus_a_oe_n_o),
    .bus_b_oe_n_o(bus_b_oe_n_o), .stabilizer_on_o(stabilizer_on_o),
    .irq_o(irq_o));
  pac_rx_model u_pac_rx_model (.clk_i(clk_i), .rst_i(rst_i),
    .bus_p_i(bus_a_p_o), .bus_n_i(bus_a_n_o), .oe_n_i(bus_a_oe_n_o),
    .word_o(rx_word), .count_o(rx_count), .pair_bad_o(pair_bad));

  // ==========================================================
  // clocks: system 10 ns, encode 125 ns with no phase relation
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    sample_strobe_p_i = 1'b0;
    sample_strobe_n_i = 1'b1;
    #1;
    forever begin
      #62;
      sample_strobe_p_i = 1'b1;
      sample_strobe_n_i = 1'b0;
      #63;
      sample_strobe_p_i = 1'b0;
      sample_strobe_n_i = 1'b1;
    end
  end

  // ==========================================================
  // compare, bus cycle and verdict tasks
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) check("ack", 32'h1, 32'h0);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    check("register read", exp, v);
  endtask
  task automatic words(input int n);
    int t, k;
    t = arise + n;
    k = 0;
    while (arise < t && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) check("word wait", 32'h1, 32'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] fw(input logic [12:0] h,
                                     input logic t);
    return {19'h0, h[12], h[11] ^ t, h[10:0]};
  endfunction

  // ==========================================================
  // analog feed, sample history and word comparisons
  always @(posedge clk_i) begin
    enc_d <= sample_strobe_p_i;
    a_d <= bus_a_p_o.data_valid_strobe;
    cnt_d <= rx_count;
    if (enc_d && !sample_strobe_p_i) begin
      analog_code_i <= nxt;
      analog_over_i <= nxt[11] & nxt[1];
      nxt <= nxt + 12'h2d7;
    end
    if (!enc_d && sample_strobe_p_i) begin
      hist[rises] <= {analog_over_i, analog_code_i};
      rises <= rises + 10'h001;
    end
    if (rst_i) rises <= 10'h000;
    if (!a_d && bus_a_p_o.data_valid_strobe === 1'b1) begin
      arise <= arise + 1;
      if (skip > 0) skip <= skip - 1;
      else if (sim_on) begin
        check("bus a", fw(hist[rises - 10'h006], tc),
          32'({bus_a_p_o.range_exceed_flag, bus_a_p_o.sample_bits}));
        check("bus b", fw(hist[rises - 10'h007], tc),
          32'({bus_b_o.range_exceed_flag, bus_b_o.sample_bits}));
      end
    end
    if (rx_count != cnt_d && chk_on && skip == 0)
      check("rx word", fw(hist[rises - 10'h006], tc),
        32'({rx_word.range_exceed_flag, rx_word.sample_bits}));
  end

  // ==========================================================
  // watchdog
  initial begin
    #400_000;
    mismatches++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, tc, sim_on, chk_on} = 6'h00;
    {wb_adr_i, wb_dat_i, analog_code_i, analog_over_i} = '0;
    {enc_d, a_d, cnt_d, skip, arise, checks, mismatches} = '0;
    wb_sel_i = 4'hf;
    nxt = 12'h0a5;
    rises = 10'h000;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("oe a", 32'h0, 32'(bus_a_oe_n_o));
    check("oe b", 32'h1, 32'(bus_b_oe_n_o));
    rd(REG_CTRL, 32'h0000_0003);
    rd(REG_STAT, 32'h0000_0000);
    rd(REG_MASK, 32'h0000_0000);
    rd(REG_DATA, 32'h0000_0000);
    wb(1'b1, REG_DATA, 32'h0000_ffff);
    rd(8'h10, 32'h0000_0000);
    // differential stream in each format
    chk_on = 1'b1;
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, REG_CTRL, 32'({f[1:0], 2'b11}));
      tc = f[1];
      skip = 3;
      words(8);
      check("stabilizer", 32'(f == 1 || f == 2), 32'(stabilizer_on_o));
      wb(1'b0, REG_DATA, 32'h0000_0000);
      check("mode", 32'h0, 32'(v[15:14]));
      check("stab bit", 32'(f == 1 || f == 2), 32'(v[13]));
    end
    check("leg pairs", 32'h0, 32'(pair_bad));
    // single-ended styles
    tc = 1'b0;
    for (int s = 0; s < 3; s++) begin
      chk_on = (s == 0);
      sim_on = (s == 1);
      wb(1'b1, REG_CTRL, 32'(s));
      skip = 4;
      words(10);
      check("oe a", 32'h0, 32'(bus_a_oe_n_o));
      check("oe b", 32'(s == 0), 32'(bus_b_oe_n_o));
    end
    {sim_on, chk_on} = 2'b00;
    // nap: outputs off, nothing reaches the receiver
    wb(1'b1, REG_CTRL, 32'h0000_0013);
    repeat (3) @(posedge clk_i);
    hold = rx_count;
    check("nap oe", 32'h3, 32'({bus_a_oe_n_o, bus_b_oe_n_o}));
    wb(1'b0, REG_DATA, 32'h0000_0000);
    check("stab bit", 32'h0, 32'(v[13]));
    check("mode", 32'h1, 32'(v[15:14]));
    repeat (250) @(posedge clk_i);
    check("rx count", 32'(hold), 32'(rx_count));
    // sleep: frozen, status cleared, interrupt masked in
    wb(1'b1, REG_CTRL, 32'h0000_0033);
    repeat (40) @(posedge clk_i);
    wb(1'b1, REG_STAT, 32'h0000_0003);
    rd(REG_STAT, 32'h0000_0000);
    wb(1'b1, REG_MASK, 32'h0000_0001);
    check("irq", 32'h0, 32'(irq_o));
    wb(1'b0, REG_DATA, 32'h0000_0000);
    check("stab bit", 32'h0, 32'(v[13]));
    check("mode", 32'h2, 32'(v[15:14]));
    // running with outputs off: events return, interrupt rises
    wb(1'b1, REG_CTRL, 32'h0000_0023);
    words(3);
    repeat (3) @(posedge clk_i);
    check("oe off", 32'h1, 32'(bus_a_oe_n_o));
    check("irq", 32'h1, 32'(irq_o));
    wb(1'b0, REG_DATA, 32'h0000_0000);
    check("stab bit", 32'h0, 32'(v[13]));
    check("mode", 32'h0, 32'(v[15:14]));
    wb(1'b1, REG_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check("irq", 32'h0, 32'(irq_o));
    wrap_up();
  end
endmodule // tb_top
